// >>> rtl/interrupt_vector_controller.sv
`timescale 1ns/1ps
module interrupt_vector_controller (
	input  wire logic                  hclk,      // system clock
	input  wire logic                  hresetn,   // async reset, low
	input  wire logic                  hsel,      // slave select
	input  wire logic [31:0]           haddr,     // byte address
	input  wire logic [1:0]            htrans,    // transfer type
	input  wire logic                  hwrite,    // write access
	input  wire logic [2:0]            hsize,     // word only
	input  wire logic [31:0]           hwdata,    // write data
	input  wire logic                  hready,    // bus ready
	output logic                       hreadyout, // slave ready
	output logic                       hresp,     // always okay
	output logic [31:0]                hrdata,    // read data
	input  wire logic [17:0]           src_pulse, // direct source events
	input  wire irq_vec_pkg::sub_vec_t sub_event, // grouped sub-events
	input  wire irq_vec_pkg::core_rsp_s core_rsp, // ack and return
	output irq_vec_pkg::core_req_s     core_req,  // request and vector
	output logic                       irq        // event interrupt
);
	irq_vec_pkg::bus_state_e state_reg;
	logic [11:0] addr_reg;
	logic [31:0] hrdata_reg;
	logic [31:0] rd_val;
	logic        take;
	logic        wr;
	logic [7:0]  en_a_reg;
	logic [7:0]  en_b_reg;
	logic [7:0]  en_c_reg;
	logic [17:0] pend_reg;
	logic [17:0] stat_reg;
	logic [17:0] ien_reg;
	logic [17:0] prio_reg;
	logic [7:0]  subm_reg [irq_vec_pkg::NGRP];
	logic [7:0]  subf_reg [irq_vec_pkg::NGRP];
	logic [7:0]  cond_d_reg;
	logic [7:0]  grp_cond;
	logic [7:0]  grp_set;
	logic [17:0] grp_map;
	logic [17:0] flag_set;
	logic [17:0] ack_vec;
	logic [17:0] pend_clr;
	logic [17:0] src_en;
	logic [17:0] cand;
	logic        hi_any;
	logic        lo_any;
	logic [4:0]  hi_idx;
	logic [4:0]  lo_idx;
	logic        sel_any;
	logic [4:0]  sel_id;
	logic        sel_lvl;
	logic        act_hi_reg;
	logic        act_lo_reg;
	logic        req_reg;
	logic [4:0]  id_reg;
	logic        lvl_reg;
	logic [15:0] vec_reg;
	logic        ack;

	// sub-register window hit: bit 3 is the hit, bits 2:0 the group
	function automatic logic [3:0] sub_hit(input logic [11:0] a,
		input logic [11:0] base);
		sub_hit = {(a[11:5] == base[11:5]), a[4:2]};
	endfunction : sub_hit

	// bus slave: writes finish with no wait, reads take one wait state
	assign take      = hsel & hready & htrans[1];
	assign wr        = (state_reg == irq_vec_pkg::BUS_WRITE);
	assign hreadyout = (state_reg != irq_vec_pkg::BUS_RWAIT);
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_reg;

	// address phase capture and data phase tracking
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= irq_vec_pkg::BUS_IDLE;
			addr_reg  <= 12'h000;
		end else if (state_reg == irq_vec_pkg::BUS_RWAIT) begin
			state_reg <= irq_vec_pkg::BUS_ROUT;
		end else if (take) begin
			addr_reg  <= haddr[11:0];
			state_reg <= hwrite ? irq_vec_pkg::BUS_WRITE
				: irq_vec_pkg::BUS_RWAIT;
		end else begin
			state_reg <= irq_vec_pkg::BUS_IDLE;
		end
	end

	// read data is loaded during the wait, so a write just before is seen
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_reg <= 32'h00000000;
		end else if (state_reg == irq_vec_pkg::BUS_RWAIT) begin
			hrdata_reg <= rd_val;
		end
	end

	// read decode; unmapped offsets and the clear register read zero
	always_comb begin
		logic [3:0] hm;
		logic [3:0] hf;
		hm = sub_hit(addr_reg, irq_vec_pkg::ADDR_SUBM);
		hf = sub_hit(addr_reg, irq_vec_pkg::ADDR_SUBF);
		rd_val = 32'h00000000;
		if (addr_reg == irq_vec_pkg::ADDR_EN_A) begin
			rd_val = {24'h000000, en_a_reg};
		end else if (addr_reg == irq_vec_pkg::ADDR_EN_B) begin
			rd_val = {24'h000000, en_b_reg};
		end else if (addr_reg == irq_vec_pkg::ADDR_EN_C) begin
			rd_val = {24'h000000, en_c_reg};
		end else if (addr_reg == irq_vec_pkg::ADDR_PEND) begin
			rd_val = {14'h0000, pend_reg};
		end else if (addr_reg == irq_vec_pkg::ADDR_STAT) begin
			rd_val = {14'h0000, stat_reg};
		end else if (addr_reg == irq_vec_pkg::ADDR_IEN) begin
			rd_val = {14'h0000, ien_reg};
		end else if (addr_reg == irq_vec_pkg::ADDR_PRIO) begin
			rd_val = {14'h0000, prio_reg};
		end else if (hm[3]) begin
			rd_val = {24'h000000, subm_reg[hm[2:0]]};
		end else if (hf[3]) begin
			rd_val = {24'h000000, subf_reg[hf[2:0]]};
		end
	end

	// cpu enable registers; unused bits are masked off on write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			en_a_reg <= irq_vec_pkg::EN_RST;
			en_b_reg <= irq_vec_pkg::EN_RST;
			en_c_reg <= irq_vec_pkg::EN_RST;
		end else if (wr) begin
			if (addr_reg == irq_vec_pkg::ADDR_EN_A) begin
				en_a_reg <= hwdata[7:0] & irq_vec_pkg::EN_A_MASK;
			end else if (addr_reg == irq_vec_pkg::ADDR_EN_B) begin
				en_b_reg <= hwdata[7:0] & irq_vec_pkg::EN_B_MASK;
			end else if (addr_reg == irq_vec_pkg::ADDR_EN_C) begin
				en_c_reg <= hwdata[7:0] & irq_vec_pkg::EN_C_MASK;
			end
		end
	end

	// event interrupt enable and per-source priority level
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ien_reg  <= 18'h00000;
			prio_reg <= 18'h00000;
		end else if (wr) begin
			if (addr_reg == irq_vec_pkg::ADDR_IEN) begin
				ien_reg <= hwdata[17:0];
			end else if (addr_reg == irq_vec_pkg::ADDR_PRIO) begin
				prio_reg <= hwdata[17:0];
			end
		end
	end

	// peripheral sub-masks and sub-flags, one set per grouped source
	genvar g;
	generate
		for (g = 0; g < irq_vec_pkg::NGRP; g++) begin : grp
			logic [3:0] hm;
			logic [3:0] hf;
			assign hm = sub_hit(addr_reg, irq_vec_pkg::ADDR_SUBM);
			assign hf = sub_hit(addr_reg, irq_vec_pkg::ADDR_SUBF);

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					subm_reg[g] <= 8'h00;
				end else if (wr && hm[3] && hm[2:0] == 3'(g)) begin
					subm_reg[g] <= hwdata[7:0];
				end
			end

			// a sub-event landing on a clear still sets the flag
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					subf_reg[g] <= 8'h00;
				end else if (wr && hf[3] && hf[2:0] == 3'(g)) begin
					subf_reg[g] <= (subf_reg[g] & ~hwdata[7:0])
						| sub_event[g];
				end else begin
					subf_reg[g] <= subf_reg[g] | sub_event[g];
				end
			end

			// ports follow the level, others take the rising edge
			assign grp_cond[g] = |(subf_reg[g] & subm_reg[g]);
			assign grp_set[g]  = irq_vec_pkg::GRP_LEVEL[g]
				? grp_cond[g]
				: grp_cond[g] & ~cond_d_reg[g];
		end
	endgenerate

	// edge history of merged group conditions
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cond_d_reg <= 8'h00;
		end else begin
			cond_d_reg <= grp_cond;
		end
	end

	// route each group onto its source number
	always_comb begin
		grp_map = 18'h00000;
		for (int i = 0; i < irq_vec_pkg::NGRP; i++) begin
			grp_map[irq_vec_pkg::GRP_SRC[i]] = grp_set[i];
		end
	end

	// flags set whatever the enables say
	assign flag_set = (src_pulse & ~irq_vec_pkg::GRP_MASK)
		| grp_map;

	// entry acknowledge names the source that was presented
	assign ack = core_rsp.ack & req_reg;
	always_comb begin
		ack_vec = 18'h00000;
		if (ack) begin
			ack_vec[id_reg] = 1'b1;
		end
	end

	// entry and software clears of the pending flags
	always_comb begin
		pend_clr = ack_vec & irq_vec_pkg::AUTO_CLR;
		if (wr && addr_reg == irq_vec_pkg::ADDR_PEND) begin
			pend_clr = pend_clr | hwdata[17:0];
		end
	end

	// cpu pending flags: set beats software and entry clears
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_reg <= 18'h00000;
		end else begin
			pend_reg <= (pend_reg & ~pend_clr) | flag_set;
		end
	end

	// sticky event status for the system interrupt line
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stat_reg <= 18'h00000;
		end else if (wr && addr_reg == irq_vec_pkg::ADDR_CLR) begin
			stat_reg <= (stat_reg & ~hwdata[17:0]) | flag_set;
		end else begin
			stat_reg <= stat_reg | flag_set;
		end
	end

	assign irq = |(stat_reg & ien_reg);

	// individual enables per source, then the global gate
	assign src_en = {en_c_reg[5], en_c_reg[0], en_c_reg[4], en_c_reg[3],
		en_b_reg[5:0], en_c_reg[2], en_c_reg[1], en_a_reg[5:0]};
	assign cand = pend_reg & src_en
		& {18{en_a_reg[irq_vec_pkg::GLOBAL_EN_BIT]}};

	prio_pick u_pick_hi (
		.vec (cand & prio_reg),
		.any (hi_any),
		.idx (hi_idx)
	);

	prio_pick u_pick_lo (
		.vec (cand & ~prio_reg),
		.any (lo_any),
		.idx (lo_idx)
	);

	// only a strictly higher level may break into a running service
	always_comb begin
		sel_any = 1'b0;
		sel_id  = hi_idx;
		sel_lvl = 1'b1;
		if (act_hi_reg) begin
			sel_any = 1'b0;
		end else if (act_lo_reg) begin
			sel_any = hi_any;
		end else if (hi_any) begin
			sel_any = 1'b1;
		end else begin
			sel_any = lo_any;
			sel_id  = lo_idx;
			sel_lvl = 1'b0;
		end
	end

	// detection stage: one registered cycle before the core's call
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_reg <= 1'b0;
			id_reg  <= 5'h00;
			lvl_reg <= 1'b0;
			vec_reg <= irq_vec_pkg::VEC_BASE;
		end else begin
			req_reg <= sel_any & ~ack;
			id_reg  <= sel_id;
			lvl_reg <= sel_lvl;
			vec_reg <= irq_vec_pkg::VEC_BASE
				+ {8'h00, sel_id, 3'b000};
		end
	end

	// in-service levels; a return closes the higher one first
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			act_hi_reg <= 1'b0;
			act_lo_reg <= 1'b0;
		end else if (ack) begin
			if (lvl_reg) begin
				act_hi_reg <= 1'b1;
			end else begin
				act_lo_reg <= 1'b1;
			end
		end else if (core_rsp.reti) begin
			if (act_hi_reg) begin
				act_hi_reg <= 1'b0;
			end else begin
				act_lo_reg <= 1'b0;
			end
		end
	end

	// strobe and vector toward the core
	assign core_req.req    = req_reg;
	assign core_req.vector = vec_reg;
endmodule : interrupt_vector_controller

// >>> rtl/irq_vec_pkg.sv
// Behaviour
// - eighteen sources, source n vectors to address 3 plus 8 times n
// - global enable bit 7 resets low; low blocks every request
// - enable group a: sleep, cipher, serial b rx, serial a rx, converter, fifo
// - enable group b: port a, timers four to one, dma completion
// - sources 0-5 group a, 8-13 group b, 6,7,14-17 group c
// - fifo, converter, serial rx and timer flags clear on service entry
// - ports, timers and radio general merge masked peripheral sub-flags
// - port sources are level triggered; flag follows the condition
// - enable group c: watchdog, port b, tx b, tx a, port c, radio
// - flags set regardless of enables; enabled flags request next cycle
// - running service preempted only by strictly higher priority
// - one detect cycle precedes the core's six-cycle forced call
package irq_vec_pkg;
	localparam int NSRC = 18;
	localparam int NGRP = 8;
	// printed offsets are register indices; byte address is four times
	localparam logic [9:0]  IDX_EN_A  = 10'h0a8;
	localparam logic [9:0]  IDX_EN_B  = 10'h0b8;
	localparam logic [9:0]  IDX_EN_C  = 10'h09a;
	localparam logic [11:0] ADDR_EN_A = {IDX_EN_A, 2'b00};
	localparam logic [11:0] ADDR_EN_B = {IDX_EN_B, 2'b00};
	localparam logic [11:0] ADDR_EN_C = {IDX_EN_C, 2'b00};
	localparam logic [11:0] ADDR_PEND = 12'h000;
	localparam logic [11:0] ADDR_STAT = 12'h004;
	localparam logic [11:0] ADDR_CLR  = 12'h008;
	localparam logic [11:0] ADDR_IEN  = 12'h00c;
	localparam logic [11:0] ADDR_PRIO = 12'h010;
	localparam logic [11:0] ADDR_SUBM = 12'h100;
	localparam logic [11:0] ADDR_SUBF = 12'h140;
	localparam int          GLOBAL_EN_BIT = 7;
	localparam logic [7:0]  EN_RST    = 8'h00;
	localparam logic [7:0]  EN_A_MASK = 8'hbf;
	localparam logic [7:0]  EN_B_MASK = 8'h3f;
	localparam logic [7:0]  EN_C_MASK = 8'h3f;
	localparam logic [15:0] VEC_BASE  = 16'h0003;
	localparam logic [17:0] AUTO_CLR  = 18'h01e0f;
	localparam logic [17:0] GRP_MASK  = 18'h1be40;
	localparam logic [7:0]  GRP_LEVEL = 8'h61;
	localparam logic [4:0]  GRP_SRC [NGRP] = '{5'h06, 5'h09, 5'h0a,
		5'h0b, 5'h0c, 5'h0d, 5'h0f, 5'h10};

	typedef logic [NGRP-1:0][7:0] sub_vec_t;

	typedef struct packed {
		logic        req;
		logic [15:0] vector;
	} core_req_s;

	typedef struct packed {
		logic ack;
		logic reti;
	} core_rsp_s;

	typedef enum logic [3:0] {
		BUS_IDLE  = 4'b0001,
		BUS_WRITE = 4'b0010,
		BUS_RWAIT = 4'b0100,
		BUS_ROUT  = 4'b1000
	} bus_state_e;
endpackage : irq_vec_pkg

// >>> rtl/prio_pick.sv
`timescale 1ns/1ps
// lowest set index of a request vector
module prio_pick (
	input  wire logic [17:0] vec, // candidate requests
	output logic             any, // at least one candidate
	output logic [4:0]       idx  // lowest candidate number
);
	// scan downward so the lowest number is written last
	always_comb begin
		any = 1'b0;
		idx = 5'h00;
		for (int i = 17; i >= 0; i--) begin
			if (vec[i]) begin
				any = 1'b1;
				idx = 5'(i);
			end
		end
	end
endmodule : prio_pick

// >>> testbench/irq_ctrl_monitor.sv
`timescale 1ns/1ps
// port-level checks; only enable group a is shadowed from the bus
module irq_ctrl_monitor (
	input wire logic                   hclk,      // clock
	input wire logic                   hresetn,   // reset, low
	input wire logic                   hsel,      // select
	input wire logic [31:0]            haddr,     // address
	input wire logic [1:0]             htrans,    // transfer
	input wire logic                   hwrite,    // write
	input wire logic [2:0]             hsize,     // size
	input wire logic [31:0]            hwdata,    // write data
	input wire logic                   hready,    // bus ready
	input wire logic                   hreadyout, // slave ready
	input wire logic                   hresp,     // response
	input wire logic [31:0]            hrdata,    // read data
	input wire logic [17:0]            src_pulse, // events
	input wire irq_vec_pkg::sub_vec_t  sub_event, // sub-events
	input wire irq_vec_pkg::core_rsp_s core_rsp,  // core answer
	input wire irq_vec_pkg::core_req_s core_req,  // request
	input wire logic                   irq        // level irq
);
	logic take;   // transfer accepted
	logic rd_a;   // read of enable a
	logic rd_bc;  // read of enable b or c
	logic wr_a_q; // enable a write in data phase
	logic glob_q; // shadow of the global enable
	assign take = hsel && hready && htrans[1];
	assign rd_a = take && !hwrite && haddr[11:0] == irq_vec_pkg::ADDR_EN_A;
	assign rd_bc = take && !hwrite && (haddr[11:0] == irq_vec_pkg::ADDR_EN_B
		|| haddr[11:0] == irq_vec_pkg::ADDR_EN_C);

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// shadow lands on the same edge as the real register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_a_q <= 1'b0;
			glob_q <= 1'b0;
		end else begin
			wr_a_q <= take && hwrite && haddr[11:0] == irq_vec_pkg::ADDR_EN_A;
			if (wr_a_q)
				glob_q <= hwdata[7];
		end
	end

	a_write_nowait: assert property (take && hwrite |=> hreadyout)
		else $error("write data phase stalled");
	a_read_wait: assert property (
		take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_en_a_unused: assert property (
		rd_a |=> ##1 (hrdata[31:8] == 24'h0 && !hrdata[6]))
		else $error("enable a unused bits not zero");
	a_en_bc_unused: assert property (rd_bc |=> ##1 hrdata[31:6] == 26'h0)
		else $error("enable b or c unused bits not zero");
	a_vec_form: assert property (
		core_req.req |-> core_req.vector[2:0] == 3'h3
		&& core_req.vector <= 16'h008b)
		else $error("vector outside table");
	a_ack_drops_req: assert property (
		core_req.req && core_rsp.ack |=> !core_req.req)
		else $error("request held after entry");
	a_global_gate: assert property ((!glob_q) [*2] |-> !core_req.req)
		else $error("request while globally disabled");
	a_reset_idle: assert property (
		$rose(hresetn) |-> !core_req.req && !irq && hreadyout)
		else $error("outputs busy after reset");

	c_entry: cover property (core_req.req && core_rsp.ack);
	c_irq: cover property (irq);
	c_global: cover property (glob_q ##1 core_req.req);
endmodule : irq_ctrl_monitor

// >>> testbench/core_model.sv
`timescale 1ns/1ps
// core side: enters service after a chosen wait, returns on command
module core_model (
	input  wire logic                   hclk,      // clock
	input  wire logic                   hresetn,   // reset, low
	input  wire irq_vec_pkg::core_req_s core_req,  // request
	input  wire logic [1:0]             delay,     // ack wait cycles
	input  wire logic                   ret_cmd,   // return request
	output irq_vec_pkg::core_rsp_s      core_rsp,  // ack and return
	output logic                        taken,     // entry seen
	output logic [15:0]                 taken_vec  // vector entered
);
	logic [1:0] wait_cnt; // cycles the request has waited

	// ack is one cycle only, so a held request is never entered twice
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			core_rsp <= '0;
			taken <= 1'b0;
			taken_vec <= 16'h0000;
			wait_cnt <= 2'h0;
		end else begin
			core_rsp.reti <= ret_cmd;
			// an ack that meets no request is ignored by the controller
			taken <= core_rsp.ack & core_req.req;
			if (core_rsp.ack) begin
				taken_vec <= core_req.vector;
				core_rsp.ack <= 1'b0;
				wait_cnt <= 2'h0;
			end else if (core_req.req && wait_cnt >= delay)
				core_rsp.ack <= 1'b1;
			else if (core_req.req)
				wait_cnt <= wait_cnt + 2'h1;
			else
				wait_cnt <= 2'h0;
		end
	end
endmodule : core_model

// >>> testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic                   hclk, hresetn, hsel, hwrite, ret_cmd;
	logic                   hreadyout, hresp, irq, taken;
	logic [31:0]            haddr, hwdata, hrdata, rd, d;
	logic [1:0]             htrans, delay;
	logic [2:0]             hsize;
	logic [17:0]            src_pulse;
	logic [15:0]            taken_vec;
	irq_vec_pkg::sub_vec_t  sub_event;
	irq_vec_pkg::core_req_s core_req;
	irq_vec_pkg::core_rsp_s core_rsp;
	int                     fails, cmp_count, seed, n;

	interrupt_vector_controller interrupt_vector_controller_inst (.hclk,
		.hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .src_pulse,
		.sub_event, .core_rsp, .core_req, .irq);
	core_model core_model_inst (.hclk, .hresetn, .core_req, .delay,
		.ret_cmd, .core_rsp, .taken, .taken_vec);

	always #2.5 hclk = ~hclk;

	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// bounded wait for taken (sel 1) or hreadyout (sel 0)
	task automatic await(input logic sel);
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while ((sel ? taken : hreadyout) !== 1'b1 && k < 60);
		if ((sel ? taken : hreadyout) !== 1'b1) begin
			fails++;
			give_verdict();
		end
	endtask : await

	task automatic bus(input logic wr, input logic [11:0] a,
		input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		hwrite <= wr;
		htrans <= 2'b10;
		await(1'b0);
		htrans <= 2'b00;
		hwdata <= wd;
		await(1'b0);
		rd = hrdata;
	endtask : bus

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rdc

	task automatic take(input int exp);
		await(1'b1);
		chk(taken_vec, exp);
	endtask : take

	task automatic ret();
		ret_cmd <= 1'b1;
		@(posedge hclk);
		ret_cmd <= 1'b0;
		repeat (2) @(posedge hclk);
	endtask : ret

	task automatic quiet();
		repeat (10) begin
			@(posedge hclk);
			chk({31'h0, taken}, 32'h0);
		end
	endtask : quiet

	function automatic int grp(input int s);
		case (s)
			6: return 0;
			9, 10, 11, 12, 13: return s - 8;
			15: return 6;
			16: return 7;
			default: return 8;
		endcase
	endfunction : grp

	// grouped sources are raised through their sub-event bit 0
	task automatic fire(input int s);
		if (grp(s) < 8)
			sub_event[grp(s)] <= 8'h01;
		else
			src_pulse <= 18'h1 << s;
		@(posedge hclk);
		sub_event <= '0;
		src_pulse <= '0;
	endtask : fire

	function automatic logic [11:0] sub_addr(input int s);
		return irq_vec_pkg::ADDR_SUBF + 12'(4 * grp(s));
	endfunction : sub_addr

	initial begin
		{hclk, hresetn, hsel, hwrite, ret_cmd} = '0;
		{haddr, hwdata, htrans, delay, src_pulse} = '0;
		hsize = 3'h2;
		sub_event = '0;
		{fails, cmp_count} = '0;
		seed = 10;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		rdc(irq_vec_pkg::ADDR_EN_A, 32'h0);
		rdc(irq_vec_pkg::ADDR_EN_B, 32'h0);
		rdc(irq_vec_pkg::ADDR_EN_C, 32'h0);
		rdc(12'h7f0, 32'h0);
		repeat (4) begin
			d = $random(seed);
			bus(1'b1, irq_vec_pkg::ADDR_EN_A, d);
			bus(1'b1, irq_vec_pkg::ADDR_EN_B, d);
			bus(1'b1, irq_vec_pkg::ADDR_EN_C, d);
			rdc(irq_vec_pkg::ADDR_EN_A, d & 32'hbf);
			rdc(irq_vec_pkg::ADDR_EN_B, d & 32'h3f);
			rdc(irq_vec_pkg::ADDR_EN_C, d & 32'h3f);
		end
		for (n = 0; n < 8; n++)
			bus(1'b1, irq_vec_pkg::ADDR_SUBM + 12'(4 * n), 32'hff);
		bus(1'b1, irq_vec_pkg::ADDR_EN_B, 32'h3f);
		bus(1'b1, irq_vec_pkg::ADDR_EN_C, 32'h3f);
		bus(1'b1, irq_vec_pkg::ADDR_EN_A, 32'h3f);
		// two sources at once while the global enable is off
		src_pulse <= 18'h0000a;
		@(posedge hclk);
		src_pulse <= '0;
		quiet();
		bus(1'b1, irq_vec_pkg::ADDR_EN_A, 32'hbf);
		take(32'h0b);
		ret();
		take(32'h1b);
		ret();
		// every source in turn, with a random core response time
		for (n = 0; n < 18; n++) begin
			delay <= 2'($random(seed));
			fire(n);
			take(3 + 8 * n);
			bus(1'b0, irq_vec_pkg::ADDR_PEND, 32'h0);
			chk(rd[n], !(n < 4 || (n > 8 && n < 13)));
			if (n == 6 || n == 13 || n == 15) begin
				bus(1'b1, irq_vec_pkg::ADDR_PEND, 32'h1 << n);
				bus(1'b0, irq_vec_pkg::ADDR_PEND, 32'h0);
				chk(rd[n], 1'b1);
				bus(1'b1, sub_addr(n), 32'h1);
				bus(1'b1, irq_vec_pkg::ADDR_PEND, 32'h1 << n);
			end else begin
				bus(1'b1, irq_vec_pkg::ADDR_PEND, 32'h1 << n);
				if (grp(n) < 8)
					bus(1'b1, sub_addr(n), 32'h1);
			end
			ret();
			rdc(irq_vec_pkg::ADDR_PEND, 32'h0);
		end
		// nesting: only the high-priority source preempts
		bus(1'b1, irq_vec_pkg::ADDR_PRIO, 32'h20000);
		fire(5);
		take(32'h2b);
		fire(4);
		quiet();
		fire(17);
		take(32'h8b);
		bus(1'b1, irq_vec_pkg::ADDR_PEND, 32'h20000);
		ret();
		bus(1'b1, irq_vec_pkg::ADDR_PEND, 32'h20);
		ret();
		take(32'h23);
		bus(1'b1, irq_vec_pkg::ADDR_PEND, 32'h10);
		ret();
		// event interrupt raised, cleared, then masked
		bus(1'b1, irq_vec_pkg::ADDR_EN_A, 32'h3f);
		// status is sticky: every earlier event is still recorded there
		bus(1'b1, irq_vec_pkg::ADDR_CLR, 32'h3ffff);
		rdc(irq_vec_pkg::ADDR_STAT, 32'h0);
		bus(1'b1, irq_vec_pkg::ADDR_IEN, 32'h3ffff);
		chk({31'h0, irq}, 32'h0);
		fire(4);
		@(posedge hclk);
		chk({31'h0, irq}, 32'h1);
		rdc(irq_vec_pkg::ADDR_STAT, 32'h10);
		bus(1'b1, irq_vec_pkg::ADDR_CLR, 32'h10);
		@(posedge hclk);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, irq_vec_pkg::ADDR_IEN, 32'h0);
		fire(4);
		@(posedge hclk);
		chk({31'h0, irq}, 32'h0);
		give_verdict();
	end
endmodule : testbench

bind interrupt_vector_controller irq_ctrl_monitor irq_ctrl_monitor_inst (
	.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
	.hready, .hreadyout, .hresp, .hrdata, .src_pulse, .sub_event,
	.core_rsp, .core_req, .irq);
